/* hdl/aux_pointer_indirect_agu.sv */
`include "agu_consts.svh"

// How it works
// [RULE1] Data address is the pointer high part over the 16-bit pointer.
// [RULE2] Low pointer writable alone; high part only via full extended write.
// [RULE3] Register-bit access uses the pointer value as bit number from LSB.
// [RULE4] Bit targets are accumulators, pointers, temporaries; top bit 39 or 15.
// [RULE5] I/O access uses the 16-bit pointer directly as I/O word address.
// [RULE6] Operand set select 0 decodes DSP operands, 1 control operands.
// [RULE7] Circular pointers get buffer start added and update within buffer.
// [RULE8] Pointer arithmetic wraps in 16 bits, never touching the high part.
// [RULE9] Plain indirect addresses at the pointer and leaves it unchanged.
// [RULE10] Post-increment addresses, then adds 1 or 2 by access width.
// [RULE11] Post-decrement addresses, then subtracts 1 or 2 by access width.
// [RULE12] Pre-increment adds 1 or 2 first, then addresses the new value.
// [RULE13] Pre-decrement subtracts 1 or 2 first, then addresses the new value.
// [RULE14] Indexed post-modify adds or subtracts temp zero or pointer zero.
// [RULE15] Indexed base-offset addresses pointer plus selected index, no update.
// [RULE16] Bit-reverse operands modify with carry running from MSB downward.
// [RULE17] Bit-reverse on circular pointer adds start value, no buffer wrap.
// [RULE18] Second-index post-modify adds or subtracts temp one.
// [RULE19] Second-index base-offset addresses pointer plus temp one, no update.
// [RULE20] Control-mode short offset adds constant 1 to 7 to unchanged pointer.
// [RULE21] Register-bit and I/O addresses ignore the pointer high part.
module aux_pointer_indirect_agu #(
    parameter int NUM_PTR = 8,
    parameter int PTR_W = 16,
    parameter int HIGH_W = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [2:0] op_ptr,
    input wire logic [1:0] op_width,
    input wire logic [1:0] op_space,
    input wire logic [3:0] bit_target,
    input wire logic [2:0] short_offset_const,
    output logic res_valid,
    output logic res_error,
    output logic [22:0] res_data_addr,
    output logic [15:0] res_io_addr,
    output logic [15:0] res_bit_num,
    output logic [3:0] res_bit_target,
    output logic [1:0] res_space
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    generate
        if (NUM_PTR != 8 || PTR_W != 16 || HIGH_W != 7) begin : g_bad_param
            $error("aux_pointer_indirect_agu supports 8 pointers of 16+7 bits only");
        end
    endgenerate

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0] aux_pointer_q [8];
    logic [6:0] aux_pointer_high_q [8];
    logic [15:0] temporaries_q [4];
    logic [15:0] buffer_start_value_q [4];
    logic [7:0] circ_en_q;
    logic legacy_compat_bit_q;
    logic operand_set_select_q;
    logic [15:0] buf_size_q;
    logic [31:0] prdata_q;
    logic unmapped_q;
    logic last_error_q;
    logic [15:0] op_count_q;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic setup_ph, wr_en, mapped;
    logic sel_xar, sel_ar, sel_tmp, sel_bsa, sel_cfg, sel_stat;
    logic [2:0] wr_ptr;
    logic [1:0] wr_sub;

    assign setup_ph = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign sel_xar = (paddr[11:5] == 7'(`AGU_OFF_XAR >> 5)) && (paddr[1:0] == 2'h0);
    assign sel_ar = (paddr[11:5] == 7'(`AGU_OFF_AR >> 5)) && (paddr[1:0] == 2'h0);
    assign sel_tmp = (paddr[11:4] == 8'(`AGU_OFF_TMP >> 4)) && (paddr[1:0] == 2'h0);
    assign sel_bsa = (paddr[11:4] == 8'(`AGU_OFF_BSA >> 4)) && (paddr[1:0] == 2'h0);
    assign sel_cfg = (paddr == `AGU_OFF_CFG);
    assign sel_stat = (paddr == `AGU_OFF_STAT);
    assign mapped = sel_xar || sel_ar || sel_tmp || sel_bsa || sel_cfg || sel_stat;
    assign wr_ptr = paddr[4:2];
    assign wr_sub = paddr[3:2];

    // No wait states; error flag captured at setup so it is stable in access
    assign pready = 1'b1;
    assign pslverr = psel && penable && unmapped_q;
    assign prdata = prdata_q;

    // ----------------------------------------------------------------
    // Operand decode and address arithmetic
    // ----------------------------------------------------------------
    function automatic logic [15:0] bit_rev(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    agu_pkg::op_code_e code;
    agu_pkg::width_e width;
    agu_pkg::space_e space;
    logic [15:0] ptr, bsa, step, idx, mod, offset;
    logic [15:0] lin_new, rev_new, circ_new, new_ptr, eff, low_addr;
    logic [6:0] ptr_high;
    logic [17:0] circ_sum;
    logic [16:0] last_bit, bit_max;
    logic circ, upd, pre, base, rev, rev_sub, bad_op, bad_access, pair, op_ok;

    always_comb begin
        code = agu_pkg::op_code_e'(op_code);
        width = agu_pkg::width_e'(op_width);
        space = agu_pkg::space_e'(op_space);
        ptr = aux_pointer_q[op_ptr];
        ptr_high = aux_pointer_high_q[op_ptr];
        circ = circ_en_q[op_ptr];
        bsa = buffer_start_value_q[op_ptr[2:1]];
        pair = (width == agu_pkg::width_32) || (width == agu_pkg::width_pair);
        step = pair ? `AGU_STEP_TWO : `AGU_STEP_ONE; // [RULE10] [RULE11]
        idx = legacy_compat_bit_q ? aux_pointer_q[0] : temporaries_q[0]; // [RULE14]
        mod = 16'h0000;
        offset = 16'h0000;
        upd = 1'b0;
        pre = 1'b0;
        base = 1'b0;
        rev = 1'b0;
        rev_sub = 1'b0;
        bad_op = 1'b0;
        unique case (code)
            agu_pkg::op_plain: begin
                upd = 1'b0; // [RULE9]
            end
            agu_pkg::op_post_inc: begin
                upd = 1'b1;
                mod = step; // [RULE10]
            end
            agu_pkg::op_post_dec: begin
                upd = 1'b1;
                mod = 16'h0000 - step; // [RULE11]
            end
            agu_pkg::op_pre_inc: begin
                upd = 1'b1;
                pre = 1'b1;
                mod = step; // [RULE12]
            end
            agu_pkg::op_pre_dec: begin
                upd = 1'b1;
                pre = 1'b1;
                mod = 16'h0000 - step; // [RULE13]
            end
            agu_pkg::op_post_add_idx: begin
                upd = 1'b1;
                mod = idx; // [RULE14]
            end
            agu_pkg::op_post_sub_idx: begin
                upd = 1'b1;
                mod = 16'h0000 - idx; // [RULE14]
            end
            agu_pkg::op_base_idx: begin
                base = 1'b1;
                offset = idx; // [RULE15]
            end
            agu_pkg::op_post_add_rev: begin
                upd = 1'b1;
                rev = 1'b1; // [RULE16]
            end
            agu_pkg::op_post_sub_rev: begin
                upd = 1'b1;
                rev = 1'b1;
                rev_sub = 1'b1; // [RULE16]
            end
            agu_pkg::op_post_add_idx1: begin
                upd = 1'b1;
                mod = temporaries_q[1]; // [RULE18]
            end
            agu_pkg::op_post_sub_idx1: begin
                upd = 1'b1;
                mod = 16'h0000 - temporaries_q[1]; // [RULE18]
            end
            agu_pkg::op_base_idx1: begin
                base = 1'b1;
                offset = temporaries_q[1]; // [RULE19]
            end
            agu_pkg::op_base_short: begin
                base = 1'b1;
                offset = {13'h0000, short_offset_const}; // [RULE20]
                bad_op = (short_offset_const == 3'h0); // [RULE20]
            end
            default: begin
                bad_op = 1'b1;
            end
        endcase

        // Operand sets differ by mode; codes outside the active set are refused
        if (operand_set_select_q) begin
            if (code == agu_pkg::op_pre_inc || code == agu_pkg::op_pre_dec
                || code == agu_pkg::op_post_add_rev || code == agu_pkg::op_post_sub_rev
                || code == agu_pkg::op_post_add_idx1 || code == agu_pkg::op_post_sub_idx1
                || code == agu_pkg::op_base_idx1) begin
                bad_op = 1'b1; // [RULE6]
            end
        end else if (code == agu_pkg::op_base_short) begin
            bad_op = 1'b1; // [RULE6]
        end

        // Pointer update, 16-bit only so the high part never sees a carry
        lin_new = ptr + mod; // [RULE8]
        if (rev_sub) begin
            rev_new = bit_rev(bit_rev(ptr) - bit_rev(idx)); // [RULE16]
        end else begin
            rev_new = bit_rev(bit_rev(ptr) + bit_rev(idx)); // [RULE16]
        end
        // Single wrap only: a modifier larger than the buffer leaves it
        circ_sum = {2'b00, ptr} + {{2{mod[15]}}, mod};
        if (circ_sum[17]) begin
            circ_new = circ_sum[15:0] + buf_size_q; // [RULE7]
        end else if (circ_sum[16:0] >= {1'b0, buf_size_q}) begin
            circ_new = circ_sum[15:0] - buf_size_q; // [RULE7]
        end else begin
            circ_new = circ_sum[15:0];
        end
        if (rev) begin
            new_ptr = rev_new; // [RULE17]
        end else if (circ && buf_size_q != 16'h0000) begin
            new_ptr = circ_new; // [RULE7]
        end else begin
            new_ptr = lin_new; // [RULE8]
        end

        // Address basis
        if (pre) begin
            eff = new_ptr; // [RULE12] [RULE13]
        end else if (base) begin
            eff = ptr + offset; // [RULE15] [RULE19] [RULE8]
        end else begin
            eff = ptr; // [RULE9]
        end
        low_addr = circ ? eff + bsa : eff; // [RULE7] [RULE17] [RULE8]

        // Access checks
        bit_max = (bit_target < `AGU_NUM_ACC) ? `AGU_BITMAX_WIDE : `AGU_BITMAX_NARROW; // [RULE4]
        last_bit = {1'b0, low_addr} + (pair ? 17'h00001 : 17'h00000);
        bad_access = 1'b0;
        if (space == agu_pkg::space_regbit) begin
            bad_access = (last_bit > bit_max) // [RULE4]
                || (width == agu_pkg::width_16) || (width == agu_pkg::width_32);
        end else begin
            bad_access = (width == agu_pkg::width_bit) || (width == agu_pkg::width_pair);
        end
        if (space == agu_pkg::space_io && pair) begin
            bad_access = 1'b1;
        end
        op_ok = !bad_op && !bad_access;
    end

    // ----------------------------------------------------------------
    // Auxiliary pointers
    // ----------------------------------------------------------------
    // Bus write wins over an operand update of the same pointer
    generate
        for (genvar n = 0; n < 8; n++) begin : g_ptr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    aux_pointer_q[n] <= `AGU_RST_PTR;
                    aux_pointer_high_q[n] <= `AGU_RST_HIGH;
                end else if (wr_en && sel_xar && wr_ptr == 3'(n)) begin
                    aux_pointer_q[n] <= pwdata[15:0]; // [RULE2]
                    aux_pointer_high_q[n] <= pwdata[22:16]; // [RULE2]
                end else if (wr_en && sel_ar && wr_ptr == 3'(n)) begin
                    aux_pointer_q[n] <= pwdata[15:0]; // [RULE2]
                end else if (op_valid && op_ok && upd && op_ptr == 3'(n)) begin
                    aux_pointer_q[n] <= new_ptr; // [RULE8]
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Temporaries, buffer starts, configuration
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < 4; k++) begin
                temporaries_q[k] <= `AGU_RST_TMP;
                buffer_start_value_q[k] <= `AGU_RST_BSA;
            end
        end else if (wr_en && sel_tmp) begin
            temporaries_q[wr_sub] <= pwdata[15:0];
        end else if (wr_en && sel_bsa) begin
            buffer_start_value_q[wr_sub] <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            circ_en_q <= `AGU_RST_CIRC;
            legacy_compat_bit_q <= 1'b0;
            operand_set_select_q <= 1'b0;
            buf_size_q <= `AGU_RST_SIZE;
        end else if (wr_en && sel_cfg) begin
            circ_en_q <= pwdata[`AGU_CFG_CIRC_LSB +: 8];
            legacy_compat_bit_q <= pwdata[`AGU_CFG_COMPAT_BIT];
            operand_set_select_q <= pwdata[`AGU_CFG_SET_BIT];
            buf_size_q <= pwdata[`AGU_CFG_SIZE_LSB +: 16];
        end
    end

    // ----------------------------------------------------------------
    // Read data, captured in the setup phase
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            unmapped_q <= 1'b0;
        end else if (setup_ph) begin
            unmapped_q <= !mapped;
            prdata_q <= 32'h0000_0000;
            if (!pwrite) begin
                if (sel_xar) begin
                    prdata_q <= {9'h000, aux_pointer_high_q[wr_ptr], aux_pointer_q[wr_ptr]};
                end else if (sel_ar) begin
                    prdata_q <= {16'h0000, aux_pointer_q[wr_ptr]};
                end else if (sel_tmp) begin
                    prdata_q <= {16'h0000, temporaries_q[wr_sub]};
                end else if (sel_bsa) begin
                    prdata_q <= {16'h0000, buffer_start_value_q[wr_sub]};
                end else if (sel_cfg) begin
                    prdata_q <= {buf_size_q, 6'h00, operand_set_select_q,
                                 legacy_compat_bit_q, circ_en_q};
                end else if (sel_stat) begin
                    prdata_q <= {op_count_q, 15'h0000, last_error_q};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Results towards the access paths
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid <= 1'b0;
            res_error <= 1'b0;
            res_data_addr <= 23'h000000;
            res_io_addr <= 16'h0000;
            res_bit_num <= 16'h0000;
            res_bit_target <= 4'h0;
            res_space <= 2'h0;
        end else begin
            res_valid <= op_valid;
            if (op_valid) begin
                res_error <= !op_ok;
                res_space <= op_space;
                res_data_addr <= {ptr_high, low_addr}; // [RULE1]
                res_io_addr <= low_addr; // [RULE5] [RULE21]
                res_bit_num <= low_addr; // [RULE3] [RULE21]
                res_bit_target <= bit_target; // [RULE4]
            end
        end
    end

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_error_q <= 1'b0;
            op_count_q <= 16'h0000;
        end else if (op_valid) begin
            last_error_q <= !op_ok;
            op_count_q <= op_count_q + 16'h0001;
        end
    end

endmodule

/* inc/agu_consts.svh */
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define AGU_OFF_XAR 12'h000
`define AGU_OFF_AR 12'h020
`define AGU_OFF_TMP 12'h040
`define AGU_OFF_BSA 12'h050
`define AGU_OFF_CFG 12'h060
`define AGU_OFF_STAT 12'h064

// ----------------------------------------------------------------
// Configuration and status fields
// ----------------------------------------------------------------
`define AGU_CFG_CIRC_LSB 0
`define AGU_CFG_COMPAT_BIT 8
`define AGU_CFG_SET_BIT 9
`define AGU_CFG_SIZE_LSB 16
`define AGU_STAT_ERR_BIT 0
`define AGU_STAT_CNT_LSB 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AGU_RST_PTR 16'h0000
`define AGU_RST_HIGH 7'h00
`define AGU_RST_TMP 16'h0000
`define AGU_RST_BSA 16'h0000
`define AGU_RST_CIRC 8'h00
`define AGU_RST_SIZE 16'h0000

// ----------------------------------------------------------------
// Addressing limits
// ----------------------------------------------------------------
`define AGU_BITMAX_WIDE 17'h00027
`define AGU_BITMAX_NARROW 17'h0000f
`define AGU_NUM_ACC 4'h4
`define AGU_STEP_ONE 16'h0001
`define AGU_STEP_TWO 16'h0002

`endif

/* inc/agu_pkg.sv */
package agu_pkg;

    typedef enum logic [3:0] {
        op_plain,
        op_post_inc,
        op_post_dec,
        op_pre_inc,
        op_pre_dec,
        op_post_add_idx,
        op_post_sub_idx,
        op_base_idx,
        op_post_add_rev,
        op_post_sub_rev,
        op_post_add_idx1,
        op_post_sub_idx1,
        op_base_idx1,
        op_base_short
    } op_code_e;

    typedef enum logic [1:0] {
        width_16,
        width_32,
        width_bit,
        width_pair
    } width_e;

    typedef enum logic [1:0] {
        space_data,
        space_mmr,
        space_regbit,
        space_io
    } space_e;

endpackage

/* verification/agu_op_source.sv */
module agu_op_source (
    input wire logic pclk,
    output logic op_valid,
    output logic [3:0] op_code,
    output logic [2:0] op_ptr,
    output logic [1:0] op_width,
    output logic [1:0] op_space,
    output logic [3:0] bit_target,
    output logic [2:0] short_offset_const
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        op_valid = 1'b0;
        op_code = 4'h0;
        op_ptr = 3'h0;
        op_width = 2'h0;
        op_space = 2'h0;
        bit_target = 4'h0;
        short_offset_const = 3'h0;
    end
    // One-cycle request; fields flipped afterwards so stale values never look valid
    task automatic issue(input logic [3:0] c, input logic [2:0] p, input logic [1:0] w,
                         input logic [1:0] s, input logic [3:0] t, input logic [2:0] k);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_code <= c;
        op_ptr <= p;
        op_width <= w;
        op_space <= s;
        bit_target <= t;
        short_offset_const <= k;
        @(posedge pclk);
        op_valid <= 1'b0;
        op_code <= ~c;
        op_ptr <= ~p;
        op_width <= ~w;
        op_space <= ~s;
        bit_target <= ~t;
        short_offset_const <= ~k;
    endtask
endmodule

/* verification/agu_sva.sv */
module agu_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [1:0] op_width,
    input wire logic [1:0] op_space,
    input wire logic [3:0] bit_target,
    input wire logic [2:0] short_offset_const,
    input wire logic res_valid,
    input wire logic res_error,
    input wire logic [22:0] res_data_addr,
    input wire logic [3:0] res_bit_target,
    input wire logic [1:0] res_space
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_res_latency: assert property (op_valid |=> res_valid)
        else $error("result missing after operand");
    a_res_only_op: assert property (!op_valid |=> !res_valid)
        else $error("result without operand");
    a_addr_held: assert property (!op_valid |=> $stable(res_data_addr))
        else $error("address moved without operand");
    a_bad_code: assert property (op_valid && op_code > 4'hd |=> res_error)
        else $error("illegal code accepted");
    a_width_space: assert property (op_valid && ((op_space == 2'h2) != op_width[1])
        |=> res_error)
        else $error("width and space mismatch accepted");
    a_io_wide: assert property (op_valid && op_space == 2'h3 && op_width == 2'h1
        |=> res_error)
        else $error("wide io access accepted");
    a_short_zero: assert property (op_valid && op_code == 4'hd && short_offset_const == 3'h0
        |=> res_error)
        else $error("zero short offset accepted");
    a_target_echo: assert property (op_valid && op_space == 2'h2
        |=> res_bit_target == $past(bit_target))
        else $error("bit target not passed on");
    a_space_echo: assert property (op_valid |=> res_space == $past(op_space))
        else $error("space not passed on");
endmodule

bind aux_pointer_indirect_agu agu_sva u_sva (.pclk(pclk), .presetn(presetn),
    .op_valid(op_valid), .op_code(op_code), .op_width(op_width), .op_space(op_space),
    .bit_target(bit_target), .short_offset_const(short_offset_const),
    .res_valid(res_valid), .res_error(res_error), .res_data_addr(res_data_addr),
    .res_bit_target(res_bit_target), .res_space(res_space));

/* verification/test_aux_pointer_indirect_agu.sv */
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module test_aux_pointer_indirect_agu;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_valid, res_valid, res_error;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] op_code, bit_target, res_bit_target, tgt;
    logic [2:0] op_ptr, short_offset_const, koff;
    logic [1:0] op_width, op_space, res_space;
    logic [22:0] res_data_addr;
    logic [15:0] res_io_addr, res_bit_num;
    int errors = 0;
    int n_checks = 0;

    always #5 pclk = ~pclk;

    aux_pointer_indirect_agu u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
        .op_ptr(op_ptr), .op_width(op_width), .op_space(op_space), .bit_target(bit_target),
        .short_offset_const(short_offset_const), .res_valid(res_valid),
        .res_error(res_error), .res_data_addr(res_data_addr), .res_io_addr(res_io_addr),
        .res_bit_num(res_bit_num), .res_bit_target(res_bit_target), .res_space(res_space));

    agu_op_source u_src (.pclk(pclk), .op_valid(op_valid), .op_code(op_code),
        .op_ptr(op_ptr), .op_width(op_width), .op_space(op_space), .bit_target(bit_target),
        .short_offset_const(short_offset_const));

    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic se);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            summarize();
        end
        `CHK(pslverr, se)
        if (!w) `CHK(prdata, e)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    task automatic run(input logic [3:0] c, input logic [1:0] w, input logic [1:0] s,
                       input logic er, input logic [22:0] e);
        u_src.issue(c, 3'h2, w, s, tgt, koff);
        #1;
        `CHK(res_valid, 1'b1)
        `CHK(res_error, er)
        if (!er) begin
            if (s == 2'h3) `CHK(res_io_addr, e[15:0])
            else if (s == 2'h2) `CHK(res_bit_num, e[15:0])
            else `CHK(res_data_addr, e)
        end
    endtask

    task automatic op(input logic [3:0] c, input logic [1:0] w, input logic [1:0] s,
                      input logic [22:0] e);
        run(c, w, s, 1'b0, e);
    endtask

    task automatic bad(input logic [3:0] c, input logic [1:0] w, input logic [1:0] s);
        run(c, w, s, 1'b1, 23'h0);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        summarize();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tgt = 4'h0;
        koff = 3'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h008, 32'h0);
        rd(12'h060, 32'h0);
        wr(12'h008, 32'h0005fffe);
        wr(12'h028, 32'h007fffff);
        rd(12'h008, 32'h0005ffff);
        op(4'h1, 2'h1, 2'h0, 23'h05ffff);
        rd(12'h008, 32'h00050001);
        op(4'h4, 2'h0, 2'h0, 23'h050000);
        op(4'h3, 2'h3, 2'h2, 23'h000002);
        op(4'h2, 2'h2, 2'h2, 23'h000002);
        op(4'h0, 2'h0, 2'h3, 23'h000001);
        op(4'h0, 2'h0, 2'h1, 23'h050001);
        wr(12'h040, 32'h0010);
        wr(12'h044, 32'hfff0);
        op(4'h5, 2'h0, 2'h0, 23'h050001);
        op(4'hb, 2'h0, 2'h0, 23'h050011);
        op(4'hc, 2'h0, 2'h0, 23'h050011);
        op(4'h7, 2'h0, 2'h0, 23'h050031);
        wr(12'h020, 32'h0003);
        wr(12'h060, 32'h0100);
        op(4'h6, 2'h0, 2'h0, 23'h050021);
        op(4'h0, 2'h0, 2'h0, 23'h05001e);
        wr(12'h060, 32'h0);
        wr(12'h040, 32'h8000);
        wr(12'h028, 32'h0);
        op(4'h8, 2'h0, 2'h0, 23'h050000);
        op(4'h8, 2'h0, 2'h0, 23'h058000);
        op(4'h9, 2'h0, 2'h0, 23'h054000);
        op(4'h0, 2'h0, 2'h0, 23'h058000);
        // Circular: start 0x100 for pointers 2/3, buffer size 4
        wr(12'h054, 32'h0100);
        wr(12'h060, 32'h00040004);
        wr(12'h028, 32'h0003);
        op(4'h1, 2'h0, 2'h0, 23'h050103);
        op(4'h0, 2'h0, 2'h0, 23'h050100);
        op(4'h8, 2'h0, 2'h0, 23'h050100);
        rd(12'h008, 32'h00058000);
        op(4'h0, 2'h0, 2'h3, 23'h008100);
        wr(12'h060, 32'h0);
        wr(12'h028, 32'h0027);
        op(4'h0, 2'h2, 2'h2, 23'h000027);
        bad(4'h0, 2'h3, 2'h2);
        tgt = 4'h4;
        bad(4'h0, 2'h2, 2'h2);
        wr(12'h028, 32'h000f);
        op(4'h0, 2'h2, 2'h2, 23'h00000f);
        bad(4'h0, 2'h3, 2'h2);
        bad(4'h0, 2'h0, 2'h2);
        bad(4'h0, 2'h2, 2'h0);
        bad(4'h0, 2'h1, 2'h3);
        bad(4'he, 2'h0, 2'h0);
        koff = 3'h7;
        bad(4'hd, 2'h0, 2'h0);
        wr(12'h060, 32'h0200);
        op(4'hd, 2'h0, 2'h0, 23'h050016);
        bad(4'h3, 2'h0, 2'h0);
        koff = 3'h0;
        bad(4'hd, 2'h0, 2'h0);
        rd(12'h064, 32'h00210001);
        op(4'h1, 2'h0, 2'h0, 23'h05000f);
        rd(12'h028, 32'h0010);
        rd(12'h064, 32'h00220000);
        apb(1'b0, 12'h002, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h0f0, 32'h0, 32'h0, 1'b1);
        summarize();
    end
endmodule
